// [dv/rbml_boot_src.sv]
// Purpose: Serial boot bit supplier
// Assumes: Bit changes on boot clock fall
// Notes:   After the stream it toggles each bit
`timescale 1ns/1ps
`default_nettype none
module rbml_boot_src (
  input  wire logic         mode_clock_i,
  input  wire logic         power_good_i,
  input  wire logic [255:0] stream_i,
  output logic              mode_data_o
);
  int idx = 0;
  always @(negedge mode_clock_i or negedge power_good_i)
    if (!power_good_i) idx <= 0;
    else idx <= idx + 1;
  assign mode_data_o = (idx < 256) ? stream_i[idx] : idx[0];
endmodule : rbml_boot_src
`default_nettype wire

// [dv/rbml_loader_props.sv]
// Purpose: Assertions on the boot mode loader ports
// Assumes: Sees only rbml_loader ports
// Notes:   Bound after endmodule
`timescale 1ns/1ps
`default_nettype none
module rbml_loader_props
  import rbml_pkg::*;
(
  // Clock and reset
  input wire logic                 mclk_i,
  input wire logic                 rst_i,
  // Initialization pins
  input wire logic                 power_good_i,
  input wire logic                 cold_reset_n_i,
  input wire logic                 reset_n_i,
  input wire logic                 mode_data_i,
  // Clocks out
  input wire logic                 mode_clock_o,
  input wire logic                 ref_clock_out_o,
  input wire logic                 system_clock_out_o,
  input wire logic [1:0]           transmit_clock_out_o,
  input wire logic [1:0]           receive_clock_out_o,
  // Core side
  input wire rbml_pkg::rbml_mode_t mode_o,
  input wire logic                 mode_valid_o,
  input wire logic                 core_reset_o,
  input wire logic                 warm_reset_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  boot_start_a: assert property ($rose(power_good_i) |-> ##[128:136] $rose(mode_clock_o))
    else $error("boot clock late");
  boot_period_a: assert property ($rose(mode_clock_o) |-> ##127 $fell(mode_clock_o) ##129 $rose(mode_clock_o))
    else $error("boot clock period");
  sys_start_a: assert property ($rose(cold_reset_n_i) |-> ##[1:6] $changed(system_clock_out_o))
    else $error("system clock idle");
  sys_hold_a: assert property (!cold_reset_n_i [*6] |-> $stable(system_clock_out_o))
    else $error("system clock early");
  tx_off_a: assert property (mode_valid_o && mode_o.tclk0_dis |=> !transmit_clock_out_o[0])
    else $error("disabled clock runs");
  ref_run_a: assert property (!$past(rst_i) |-> ref_clock_out_o != $past(ref_clock_out_o))
    else $error("ref clock stuck");
  core_hold_a: assert property (!mode_valid_o |-> core_reset_o)
    else $error("core left reset early");
  core_free_a: assert property (mode_valid_o && cold_reset_n_i && reset_n_i [*4] |-> !core_reset_o)
    else $error("core stuck in reset");
  mode_keep_a: assert property (mode_valid_o && $past(mode_valid_o) |-> $stable(mode_o))
    else $error("mode changed after load");
  warm_set_a: assert property ($fell(reset_n_i) && $past(reset_n_i, 2) && cold_reset_n_i && $past(cold_reset_n_i, 2)
    |-> ##[2:4] warm_reset_o)
    else $error("warm reset not flagged");
endmodule : rbml_loader_props
bind rbml_loader rbml_loader_props chk_u (.*);
`default_nettype wire

// [dv/rbml_loader_tb.sv]
// Purpose: Self-checking bench for the boot mode loader
// Assumes: 20 MHz clock, inputs driven on falling edge
// Notes:   One full 256-bit load
`timescale 1ns/1ps
`default_nettype none
module rbml_loader_tb;
  import rbml_pkg::*;
  logic mclk_i, rst_i, power_good_i, cold_reset_n_i, reset_n_i, mode_data_i;
  logic mode_clock_o, ref_clock_out_o, system_clock_out_o, mode_valid_o, core_reset_o, warm_reset_o;
  logic [1:0] transmit_clock_out_o, receive_clock_out_o;
  rbml_mode_t mode_o;
  logic [255:0] strm = 256'h0a5a4;
  int n_fail, samples_checked, cyc;
  rbml_loader dut_u (.*);
  rbml_boot_src src_u (.mode_clock_i(mode_clock_o), .power_good_i(power_good_i),
    .stream_i(strm), .mode_data_o(mode_data_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic t_load;
    int i;
    @(negedge mclk_i) power_good_i = 1;
    for (i = 0; i < 70000 && mode_valid_o !== 1'b1; i++)
    begin
      @(negedge mclk_i);
      if (i == 1000) chk(core_reset_o, 1);
    end
    chk(mode_valid_o, 1);
    chk(i >= 255 * 256 && i <= 256 * 256, 1);
    chk(mode_o, strm[18:0]);
    repeat (600) @(negedge mclk_i);
    chk(mode_o, strm[18:0]);
    $display("test load done");
  endtask : t_load
  task automatic t_period;
    int n;
    n = 0;
    while (mode_clock_o !== 1'b0) @(negedge mclk_i);
    while (mode_clock_o !== 1'b1) @(negedge mclk_i);
    while (mode_clock_o !== 1'b0)
    begin
      n++;
      @(negedge mclk_i);
    end
    while (mode_clock_o !== 1'b1)
    begin
      n++;
      @(negedge mclk_i);
    end
    chk(n, 256);
    $display("test period done");
  endtask : t_period
  task automatic t_release;
    logic [5:0] s;
    chk(system_clock_out_o, 0);
    while (ref_clock_out_o !== 1'b1) @(negedge mclk_i);
    cold_reset_n_i = 1;
    reset_n_i = 1;
    repeat (8) @(negedge mclk_i);
    chk(core_reset_o, 0);
    s = {ref_clock_out_o, system_clock_out_o, transmit_clock_out_o, receive_clock_out_o};
    @(negedge mclk_i);
    chk({ref_clock_out_o, system_clock_out_o, transmit_clock_out_o, receive_clock_out_o},
      {~s[5:4], ~s[3], 1'b0, ~s[1:0]});
    $display("test release done");
  endtask : t_release
  task automatic t_warm;
    chk(warm_reset_o, 0);
    while (ref_clock_out_o !== 1'b1) @(negedge mclk_i);
    reset_n_i = 0;
    repeat (4) @(negedge mclk_i);
    chk(warm_reset_o, 1);
    while (ref_clock_out_o !== 1'b1) @(negedge mclk_i);
    reset_n_i = 1;
    repeat (4) @(negedge mclk_i);
    chk(warm_reset_o, 0);
    $display("test warm done");
  endtask : t_warm
  initial
  begin
    mclk_i = 0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  initial
  begin
    rst_i = 1;
    power_good_i = 0;
    cold_reset_n_i = 0;
    reset_n_i = 0;
    repeat (16) @(negedge mclk_i);
    rst_i = 0;
    repeat (4) @(negedge mclk_i);
    t_load;
    t_period;
    t_release;
    t_warm;
    end_of_test;
  end
endmodule : rbml_loader_tb
`default_nettype wire

// [logic/rbml_loader.sv]
// Purpose: Power-good boot mode stream loader with reset and clock start
// Assumes: Pins from outside are synchronised here; one 20 MHz clock
// Notes:   Output clocks are divided levels; all but ref_clock_out_o are enable-gated
`timescale 1ns/1ps
`default_nettype none
`include "rbml_map.svh"

module rbml_loader
  import rbml_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_i,
  // Initialization pins
  input  wire logic            power_good_i,
  input  wire logic            cold_reset_n_i,
  input  wire logic            reset_n_i,
  input  wire logic            mode_data_i,
  // Boot clock and output clocks
  output logic                 mode_clock_o,
  output logic                 ref_clock_out_o,
  output logic                 system_clock_out_o,
  output logic [1:0]           transmit_clock_out_o,
  output logic [1:0]           receive_clock_out_o,
  // Core side
  output rbml_pkg::rbml_mode_t mode_o,
  output logic                 mode_valid_o,
  output logic                 core_reset_o,
  output logic                 warm_reset_o
);

  import rbml_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] pins_s;

  rbml_sync #(
    .W (4)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({power_good_i, cold_reset_n_i, reset_n_i, mode_data_i}),
    .q_o    (pins_s)
  );

  wire pgood_s  = pins_s[3];
  wire cold_n_s = pins_s[2];
  wire rst_n_s  = pins_s[1];
  wire mdata_s  = pins_s[0];

  // ****************************************
  // Boot clock divider
  // ****************************************
  logic [7:0]  div_reg;
  logic        mclk_reg;
  rbml_state_t state_reg;
  rbml_state_t state_next;
  logic [8:0]  bit_cnt_reg;
  rbml_mode_t  mode_reg;
  logic        cold_d_reg;
  logic        rst_d_reg;
  logic        clk_run_reg;
  logic        sys_reg;

  function automatic logic is_last(input logic [8:0] n);
    is_last = (n == 9'(`RBML_STREAM_BITS - 1));
  endfunction : is_last

  wire div_wrap   = (div_reg == 8'(`RBML_MODE_CLK_DIV - 1));
  wire sample_en  = (div_reg == `RBML_SAMPLE_PHASE);
  wire loading    = (state_reg == RBML_LOAD);
  wire take_bit   = loading && sample_en;
  wire keep_bit   = take_bit && (bit_cnt_reg < 9'(`RBML_CAPTURE_BITS));
  wire cold_rise  = cold_n_s && !cold_d_reg;
  wire rst_rise   = rst_n_s && !rst_d_reg;
  wire warm_start = !rst_n_s && rst_d_reg && cold_n_s;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (state_reg == RBML_IDLE && !pgood_s))
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || state_reg == RBML_IDLE)
      mclk_reg <= 1'b0;
    else if (div_wrap || sample_en)
      mclk_reg <= !mclk_reg;
  end

  // ****************************************
  // Load sequence
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RBML_IDLE: if (pgood_s) state_next = RBML_LOAD;
      RBML_LOAD: if (take_bit && is_last(bit_cnt_reg)) state_next = RBML_HOLD;
      RBML_HOLD: if (cold_n_s && rst_n_s) state_next = RBML_RUN;
      RBML_RUN:  if (!pgood_s) state_next = RBML_IDLE;
      default:   state_next = RBML_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      state_reg <= RBML_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || state_reg == RBML_IDLE)
      bit_cnt_reg <= 9'h000;
    else if (take_bit)
      bit_cnt_reg <= bit_cnt_reg + 9'h001;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      mode_reg <= rbml_mode_t'(`RBML_RESET_MODE);
    else if (keep_bit)
      mode_reg[bit_cnt_reg[4:0]] <= mdata_s;
  end

  // ****************************************
  // Reset edges and clock start
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    cold_d_reg <= rst_i ? 1'b0 : cold_n_s;
    rst_d_reg  <= rst_i ? 1'b0 : rst_n_s;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !cold_n_s)
      clk_run_reg <= 1'b0;
    else if (cold_rise)
      clk_run_reg <= 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !clk_run_reg)
      sys_reg <= 1'b0;
    else
      sys_reg <= !sys_reg;
  end

  logic core_rst_reg;
  logic warm_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      core_rst_reg <= 1'b1;
    else
      core_rst_reg <= (state_next != RBML_RUN);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || rst_rise)
      warm_reg <= 1'b0;
    else if (warm_start)
      warm_reg <= 1'b1;
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [1:0] tclk_reg;
  logic [1:0] rclk_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !clk_run_reg)
    begin
      tclk_reg <= 2'b00;
      rclk_reg <= 2'b00;
    end
    else
    begin
      tclk_reg <= {2{!sys_reg}} & ~{mode_reg.tclk1_dis, mode_reg.tclk0_dis};
      rclk_reg <= {2{!sys_reg}} & ~{mode_reg.rclk1_dis, mode_reg.rclk0_dis};
    end
  end

  logic ref_reg;

  always_ff @(posedge mclk_i)
  begin
    ref_reg <= rst_i ? 1'b0 : !ref_reg;
  end

  assign mode_clock_o         = mclk_reg;
  assign ref_clock_out_o      = ref_reg;
  assign system_clock_out_o   = sys_reg;
  assign transmit_clock_out_o = tclk_reg;
  assign receive_clock_out_o  = rclk_reg;
  assign mode_o               = mode_reg;
  assign mode_valid_o         = (state_reg == RBML_HOLD) || (state_reg == RBML_RUN);
  assign core_reset_o         = core_rst_reg;
  assign warm_reset_o         = warm_reg;

endmodule : rbml_loader

`default_nettype wire

// [logic/rbml_map.svh]
// Purpose: Constants for the reset and boot mode loader
// Assumes: 20 MHz reference clock
// Notes:   Included by the package and rbml_loader
`ifndef RBML_MAP_SVH
`define RBML_MAP_SVH

`define RBML_MODE_CLK_DIV    256
`define RBML_STREAM_BITS     256
`define RBML_CAPTURE_BITS    19
`define RBML_SAMPLE_PHASE    8'h80
`define RBML_SYS_DIV         2
`define RBML_RESET_MODE      19'h00000
`define RBML_FLD_WB_LO       1
`define RBML_FLD_DIV_LO      5
`define RBML_FLD_ENDIAN      8
`define RBML_FLD_WRMODE_LO   9
`define RBML_FLD_TMR_DIS     11
`define RBML_FLD_DRIVE_LO    13
`define RBML_FLD_TCLK0_DIS   15
`define RBML_FLD_TCLK1_DIS   16
`define RBML_FLD_RCLK0_DIS   17
`define RBML_FLD_RCLK1_DIS   18

`endif

// [logic/rbml_pkg.sv]
// Purpose: Types for the reset and boot mode loader
// Assumes: rbml_map.svh supplies the numbers
// Notes:   Mode settings travel as one packed struct
`default_nettype none
`include "rbml_map.svh"

package rbml_pkg;

  typedef struct packed {
    logic       rclk1_dis;
    logic       rclk0_dis;
    logic       tclk1_dis;
    logic       tclk0_dis;
    logic [1:0] drive;
    logic       rsvd12;
    logic       timer_dis;
    logic [1:0] write_mode;
    logic       big_endian;
    logic [2:0] clk_div;
    logic [3:0] wb_rate;
    logic       rsvd0;
  } rbml_mode_t;

  typedef enum logic [3:0] {
    RBML_IDLE    = 4'b0001,
    RBML_LOAD    = 4'b0010,
    RBML_HOLD    = 4'b0100,
    RBML_RUN     = 4'b1000
  } rbml_state_t;

endpackage : rbml_pkg

`default_nettype wire

// [logic/rbml_sync.sv]
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Single clock mclk_i
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none

module rbml_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge mclk_i)
  begin
    meta_reg <= rst_i ? '0 : d_i;
    q_reg    <= rst_i ? '0 : meta_reg;
  end

  assign q_o = q_reg;

endmodule : rbml_sync

`default_nettype wire
